// *** logic/asr_pkg.sv ***
// shared constants, types and decode functions of the async serial receiver
package asr_pkg;
    // register byte offsets on the avalon slave
    localparam logic [4:0] OFF_LINE_CTRL_ONE = 5'h00; // character length select
    localparam logic [4:0] OFF_LINE_CTRL_TWO = 5'h04; // receive interrupt enable
    localparam logic [4:0] OFF_STATUS_ONE = 5'h08; // full, noise, framing flags
    localparam logic [4:0] OFF_DATA_HIGH = 5'h0C; // ninth received bit
    localparam logic [4:0] OFF_DATA_LOW = 5'h10; // low eight received bits
    localparam logic [4:0] OFF_TICK_DIV = 5'h14; // clocks per oversample tick
    // field positions
    localparam int POS_LEN9 = 0; // in line_control_one
    localparam int POS_RIE = 0; // in line_control_two
    localparam int POS_FULL = 7; // in status_reg_one
    localparam int POS_NOISE = 2; // in status_reg_one
    localparam int POS_FERR = 1; // in status_reg_one
    localparam int POS_NINTH = 7; // in data_high_reg
    // values after reset
    localparam logic [15:0] TICK_DIV_RST = 16'h0000; // zero stops the tick
    localparam logic LINE_IDLE = 1'b1; // serial line rests high
    localparam logic [31:0] BUS_UNMAPPED = 32'h00000000; // answer to unmapped reads
    // oversample tick positions within one bit time
    localparam logic [4:0] RT_FIRST = 5'h01;
    localparam logic [4:0] RT_V1 = 5'h03;
    localparam logic [4:0] RT_V2 = 5'h05;
    localparam logic [4:0] RT_V3 = 5'h07;
    localparam logic [4:0] RT_D1 = 5'h08;
    localparam logic [4:0] RT_D3 = 5'h0A;
    localparam logic [4:0] RT_LAST = 5'h10; // sixteen ticks per bit
    localparam logic [3:0] BITS_SHORT = 4'h8;
    localparam logic [3:0] BITS_LONG = 4'h9;
    // receiver states
    typedef enum logic [1:0] {ST_SEARCH, ST_START, ST_DATA, ST_STOP} asr_state_t;
    // software controls
    typedef struct packed {
        logic len9; // nine data bits
        logic receive_irq_enable; // receive interrupt enable
        logic [15:0] div; // tick divider
    } asr_cfg_t;
    // sticky status
    typedef struct packed {
        logic full;
        logic noise;
        logic ferr;
    } asr_stat_t;
    // majority of three samples
    function automatic logic asr_maj3(input logic [2:0] v);
        return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction
    // three samples disagree
    function automatic logic asr_noisy3(input logic [2:0] v);
        return (v != 3'h0) && (v != 3'h7);
    endfunction
endpackage

// *** logic/asr_sync.sv ***
// three-flop input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module asr_sync
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic pin_in,
    output logic level
);
    logic s1_ff; // metastability catcher, read only by s2
    logic s2_ff;
    logic s3_ff;
    logic level_ff; // accepted level
    logic nxt_level;

    // accept a new level only when two settled stages agree
    always_comb
    begin
        nxt_level = level_ff;
        if (s2_ff == s3_ff)
        begin
            nxt_level = s3_ff;
        end
    end

    // register the chain
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s1_ff <= asr_pkg::LINE_IDLE;
            s2_ff <= asr_pkg::LINE_IDLE;
            s3_ff <= asr_pkg::LINE_IDLE;
            level_ff <= asr_pkg::LINE_IDLE;
        end
        else if (ce)
        begin
            s1_ff <= pin_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            level_ff <= nxt_level;
        end
    end

    assign level = level_ff;
endmodule // asr_sync

// *** logic/asr_rx.sv ***
// receive path of the async serial interface with its avalon register slave
`timescale 1ns/1ps
module asr_rx
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic rx_pin,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic rx_irq
);
    // synchronised serial input
    logic rx_lvl;

    asr_sync u_sync
    (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .pin_in(rx_pin),
        .level(rx_lvl)
    );

    // ---- oversample tick generator ----
    asr_pkg::asr_cfg_t cfg_ff, nxt_cfg; // software controls
    logic [15:0] div_cnt_ff, nxt_div_cnt; // clocks since last tick
    logic tick_ff, nxt_tick; // one-cycle oversample tick

    // divide the clock by the programmed count
    always_comb
    begin
        nxt_div_cnt = div_cnt_ff + 16'h0001;
        nxt_tick = 1'b0;
        if (cfg_ff.div == 16'h0000)
        begin
            nxt_div_cnt = 16'h0000;
        end
        else if (div_cnt_ff >= cfg_ff.div - 16'h0001)
        begin
            nxt_div_cnt = 16'h0000;
            nxt_tick = 1'b1;
        end
    end

    // register the divider
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            div_cnt_ff <= 16'h0000;
            tick_ff <= 1'b0;
        end
        else if (ce)
        begin
            div_cnt_ff <= nxt_div_cnt;
            tick_ff <= nxt_tick;
        end
    end

    // ---- receiver ----
    asr_pkg::asr_state_t state_ff, nxt_state; // frame position
    logic [4:0] rt_ff, nxt_rt; // tick number within the bit, 1..16
    logic [2:0] hist_ff, nxt_hist; // last three search samples
    logic [2:0] votes_ff, nxt_votes; // collected vote samples
    logic [8:0] shift_ff, nxt_shift; // receive shift register
    logic [3:0] bitn_ff, nxt_bitn; // data bits decided so far
    logic len9_ff, nxt_len9; // length latched for this frame
    logic fnoise_ff, nxt_fnoise; // noise seen in this frame
    logic armed_ff, nxt_armed; // last data bit was a valid one
    logic edge_seen_ff, nxt_edge_seen; // falling edge found after it
    logic [4:0] edge_cnt_ff, nxt_edge_cnt; // ticks since that edge
    logic last_smp_ff, nxt_last_smp; // previous tick sample
    logic done; // frame complete this cycle
    logic done_ferr; // stop bit missing
    logic done_brk; // break character
    logic [8:0] done_data; // received data word
    logic [2:0] v; // votes including current sample
    logic b; // majority decision
    logic [3:0] nbits; // data bits expected

    // frame recovery, stepped once per oversample tick
    always_comb
    begin
        nxt_state = state_ff;
        nxt_rt = rt_ff;
        nxt_hist = hist_ff;
        nxt_votes = votes_ff;
        nxt_shift = shift_ff;
        nxt_bitn = bitn_ff;
        nxt_len9 = len9_ff;
        nxt_fnoise = fnoise_ff;
        nxt_armed = armed_ff;
        nxt_edge_seen = edge_seen_ff;
        nxt_edge_cnt = edge_cnt_ff;
        nxt_last_smp = last_smp_ff;
        done = 1'b0;
        done_ferr = 1'b0;
        done_brk = 1'b0;
        done_data = len9_ff ? shift_ff : {1'b0, shift_ff[8:1]};
        v = {votes_ff[1:0], rx_lvl};
        b = asr_pkg::asr_maj3(v);
        nbits = len9_ff ? asr_pkg::BITS_LONG : asr_pkg::BITS_SHORT;
        if (tick_ff)
        begin
            nxt_last_smp = rx_lvl;
            case (state_ff)
                // hunt for a qualified falling edge
                asr_pkg::ST_SEARCH:
                begin
                    nxt_hist = {hist_ff[1:0], rx_lvl};
                    if (!rx_lvl && hist_ff == 3'h7)
                    begin
                        nxt_state = asr_pkg::ST_START;
                        nxt_rt = asr_pkg::RT_FIRST;
                        nxt_votes = 3'h0;
                        nxt_fnoise = 1'b0;
                        nxt_len9 = cfg_ff.len9;
                    end
                end
                // verify the start bit
                asr_pkg::ST_START:
                begin
                    nxt_rt = rt_ff + 5'h01;
                    if (rt_ff == asr_pkg::RT_V1 || rt_ff == asr_pkg::RT_V2)
                    begin
                        nxt_votes = v;
                    end
                    if (rt_ff == asr_pkg::RT_V3)
                    begin
                        nxt_votes = v;
                        if (v[0] + v[1] + v[2] > 2'd1)
                        begin
                            // glitch: back to search, noise untouched
                            nxt_state = asr_pkg::ST_SEARCH;
                            nxt_rt = 5'h00;
                            nxt_hist = 3'h0;
                        end
                        else
                        begin
                            nxt_fnoise = asr_pkg::asr_noisy3(v);
                        end
                    end
                    // late start samples only mark noise, no realign
                    if (rt_ff >= asr_pkg::RT_D1 && rt_ff <= asr_pkg::RT_D3 && rx_lvl)
                    begin
                        nxt_fnoise = 1'b1;
                    end
                    if (rt_ff == asr_pkg::RT_LAST)
                    begin
                        nxt_state = asr_pkg::ST_DATA;
                        nxt_rt = asr_pkg::RT_FIRST;
                        nxt_bitn = 4'h0;
                        nxt_armed = 1'b0;
                        nxt_edge_seen = 1'b0;
                    end
                end
                // data and stop bits
                asr_pkg::ST_DATA, asr_pkg::ST_STOP:
                begin
                    nxt_rt = rt_ff + 5'h01;
                    // watch for the falling edge after a valid one
                    if (armed_ff && !edge_seen_ff && last_smp_ff && !rx_lvl)
                    begin
                        nxt_edge_seen = 1'b1;
                        nxt_edge_cnt = asr_pkg::RT_FIRST;
                    end
                    else if (edge_seen_ff && edge_cnt_ff != asr_pkg::RT_LAST)
                    begin
                        nxt_edge_cnt = edge_cnt_ff + 5'h01;
                    end
                    if (rt_ff >= asr_pkg::RT_D1 && rt_ff < asr_pkg::RT_D3)
                    begin
                        nxt_votes = v;
                    end
                    if (rt_ff == asr_pkg::RT_D3 && state_ff == asr_pkg::ST_DATA)
                    begin
                        nxt_fnoise = fnoise_ff | asr_pkg::asr_noisy3(v);
                        nxt_shift = {b, shift_ff[8:1]};
                        nxt_bitn = bitn_ff + 4'h1;
                        if (armed_ff && edge_seen_ff && !b)
                        begin
                            // one then zero: the tick after the edge tick becomes tick one
                            nxt_rt = (edge_cnt_ff == asr_pkg::RT_LAST) ?
                                asr_pkg::RT_LAST : edge_cnt_ff + 5'h01;
                        end
                        nxt_armed = b;
                        nxt_edge_seen = 1'b0;
                    end
                    if (rt_ff == asr_pkg::RT_D3 && state_ff == asr_pkg::ST_STOP)
                    begin
                        done = 1'b1;
                        done_ferr = !b;
                        nxt_fnoise = fnoise_ff | asr_pkg::asr_noisy3(v);
                        done_brk = !b && done_data == 9'h000;
                        nxt_state = asr_pkg::ST_SEARCH;
                        nxt_rt = 5'h00;
                        nxt_hist = b ? 3'h7 : 3'h0;
                    end
                    if (nxt_rt > asr_pkg::RT_LAST && state_ff == asr_pkg::ST_DATA)
                    begin
                        nxt_rt = asr_pkg::RT_FIRST;
                        if (bitn_ff == nbits)
                        begin
                            nxt_state = asr_pkg::ST_STOP;
                        end
                    end
                end
                default:
                begin
                    nxt_state = asr_pkg::ST_SEARCH;
                end
            endcase
        end
    end

    // register the receiver
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_ff <= asr_pkg::ST_SEARCH;
            rt_ff <= 5'h00;
            hist_ff <= 3'h0;
            votes_ff <= 3'h0;
            shift_ff <= 9'h000;
            bitn_ff <= 4'h0;
            len9_ff <= 1'b0;
            fnoise_ff <= 1'b0;
            armed_ff <= 1'b0;
            edge_seen_ff <= 1'b0;
            edge_cnt_ff <= 5'h00;
            last_smp_ff <= asr_pkg::LINE_IDLE;
        end
        else if (ce)
        begin
            state_ff <= nxt_state;
            rt_ff <= nxt_rt;
            hist_ff <= nxt_hist;
            votes_ff <= nxt_votes;
            shift_ff <= nxt_shift;
            bitn_ff <= nxt_bitn;
            len9_ff <= nxt_len9;
            fnoise_ff <= nxt_fnoise;
            armed_ff <= nxt_armed;
            edge_seen_ff <= nxt_edge_seen;
            edge_cnt_ff <= nxt_edge_cnt;
            last_smp_ff <= nxt_last_smp;
        end
    end

    // ---- register file and avalon slave ----
    asr_pkg::asr_stat_t stat_ff, nxt_stat; // sticky flags
    logic [8:0] data_ff, nxt_data; // received character
    logic ack_ff, nxt_ack; // second cycle of an access
    logic [31:0] rdata_ff, nxt_rdata; // registered read data
    logic [31:0] rd_mux; // read selection
    logic take_wr; // write takes effect now
    logic take_rd; // read completes now

    // one wait cycle, then the access completes
    assign avs_waitrequest = (avs_read | avs_write) & !ack_ff;
    assign take_wr = avs_write & ack_ff;
    assign take_rd = avs_read & ack_ff;

    // read selection and flag, data, control updates
    always_comb
    begin
        rd_mux = asr_pkg::BUS_UNMAPPED;
        case (avs_address)
            asr_pkg::OFF_LINE_CTRL_ONE: rd_mux[asr_pkg::POS_LEN9] = cfg_ff.len9;
            asr_pkg::OFF_LINE_CTRL_TWO: rd_mux[asr_pkg::POS_RIE] = cfg_ff.receive_irq_enable;
            asr_pkg::OFF_STATUS_ONE:
            begin
                rd_mux[asr_pkg::POS_FULL] = stat_ff.full;
                rd_mux[asr_pkg::POS_NOISE] = stat_ff.noise;
                rd_mux[asr_pkg::POS_FERR] = stat_ff.ferr;
            end
            asr_pkg::OFF_DATA_HIGH: rd_mux[asr_pkg::POS_NINTH] = data_ff[8];
            asr_pkg::OFF_DATA_LOW: rd_mux[7:0] = data_ff[7:0];
            asr_pkg::OFF_TICK_DIV: rd_mux[15:0] = cfg_ff.div;
            default: rd_mux = asr_pkg::BUS_UNMAPPED;
        endcase
        nxt_ack = (avs_read | avs_write) & !ack_ff;
        nxt_rdata = (avs_read & !ack_ff) ? rd_mux : rdata_ff;
        nxt_cfg = cfg_ff;
        nxt_stat = stat_ff;
        nxt_data = data_ff;
        // software writes the controls; data and status ignore writes
        if (take_wr)
        begin
            case (avs_address)
                asr_pkg::OFF_LINE_CTRL_ONE: nxt_cfg.len9 = avs_writedata[asr_pkg::POS_LEN9];
                asr_pkg::OFF_LINE_CTRL_TWO: nxt_cfg.receive_irq_enable = avs_writedata[asr_pkg::POS_RIE];
                asr_pkg::OFF_TICK_DIV: nxt_cfg.div = avs_writedata[15:0];
                default: nxt_cfg = cfg_ff;
            endcase
        end
        // reading the low data byte releases the character
        if (take_rd && avs_address == asr_pkg::OFF_DATA_LOW)
        begin
            nxt_stat = '0;
        end
        // a new frame wins over a same-cycle clear
        if (done)
        begin
            nxt_data = done_brk ? 9'h000 : done_data;
            nxt_stat.full = 1'b1;
            nxt_stat.ferr = done_ferr;
            nxt_stat.noise = nxt_fnoise;
        end
    end

    // register the slave state
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cfg_ff <= '{len9: 1'b0, receive_irq_enable: 1'b0, div: asr_pkg::TICK_DIV_RST};
            stat_ff <= '0;
            data_ff <= 9'h000;
            ack_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
        end
        else if (ce)
        begin
            cfg_ff <= nxt_cfg;
            stat_ff <= nxt_stat;
            data_ff <= nxt_data;
            ack_ff <= nxt_ack;
            rdata_ff <= nxt_rdata;
        end
    end

    assign avs_readdata = rdata_ff;
    assign rx_irq = stat_ff.full & cfg_ff.receive_irq_enable;

    // ---- assertions ----
    sequence frame_end_s;
        ce && done;
    endsequence

    sequence start_fail_s;
        ce && tick_ff && state_ff == asr_pkg::ST_START && rt_ff == asr_pkg::RT_V3
            && ({votes_ff[1:0], rx_lvl} inside {3'h3, 3'h5, 3'h6, 3'h7});
    endsequence

    full_sets_a: assert property (@(posedge clk) disable iff (!rstn)
        frame_end_s |=> stat_ff.full && data_ff == (done_brk ? 9'h000 : done_data))
        else $error("receive full not set with data");
    ferr_with_full_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(stat_ff.ferr) |-> $rose(stat_ff.full) || $past(stat_ff.full))
        else $error("framing error set apart from full");
    irq_follows_a: assert property (@(posedge clk) disable iff (!rstn)
        frame_end_s ##1 cfg_ff.receive_irq_enable |-> rx_irq)
        else $error("interrupt missing for full character");
    start_reject_a: assert property (@(posedge clk) disable iff (!rstn)
        start_fail_s |=> state_ff == asr_pkg::ST_SEARCH && hist_ff == 3'h0)
        else $error("failed start not restarted");
    glitch_quiet_a: assert property (@(posedge clk) disable iff (!rstn)
        start_fail_s |=> !fnoise_ff)
        else $error("rejected glitch touched noise flag");
    break_clear_a: assert property (@(posedge clk) disable iff (!rstn)
        frame_end_s and done_brk |=> data_ff == 9'h000 && stat_ff.ferr)
        else $error("break did not clear data");
    stop_low_a: assert property (@(posedge clk) disable iff (!rstn)
        frame_end_s and !asr_pkg::asr_maj3({votes_ff[1:0], rx_lvl}) |=> stat_ff.ferr)
        else $error("low stop without framing error");
    short_ninth_a: assert property (@(posedge clk) disable iff (!rstn)
        frame_end_s and !len9_ff |=> data_ff[8] == 1'b0)
        else $error("ninth bit set in eight-bit mode");
    tick_single_a: assert property (@(posedge clk) disable iff (!rstn)
        ce && tick_ff && cfg_ff.div > 16'h0001 |=> !tick_ff)
        else $error("tick lasted more than one cycle");
endmodule // asr_rx

// *** bench/asr_tx_model.sv ***
// behavioural remote transmitter that drives the serial line
`timescale 1ns/1ps
module asr_tx_model
#(
    parameter int DIV = 1
)
(
    input wire logic clk,
    output logic line
);
    // idle line rests high
    initial line = 1'b1;

    // start, nb data bits lsb first, stop; flip inverts one tick of the frame
    task automatic send(input logic [8:0] d, input int nb, input logic stop, input int flip);
        logic [10:0] fr;
        fr = {1'b0, d, 1'b0};
        fr[nb + 1] = stop; // low stop with zero data forms a break
        for (int b = 0; b < nb + 2; b++)
        begin
            for (int k = 0; k < 16; k++)
            begin
                line <= fr[b] ^ ((b * 16 + k) == flip);
                repeat (DIV) @(posedge clk);
            end
        end
        line <= 1'b1;
        repeat (32 * DIV) @(posedge clk);
    endtask

    // short low pulse that is not a real start bit
    task automatic glitch(input int n);
        line <= 1'b0;
        repeat (n * DIV) @(posedge clk);
        line <= 1'b1;
        // longer than a whole frame, so a wrongly taken start would show as full
        repeat (192 * DIV) @(posedge clk);
    endtask
endmodule // asr_tx_model

// *** bench/tb_top.sv ***
// self-checking testbench of the async serial receiver
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0; // 250 MHz
    logic rstn = 1'b0; // active low reset
    logic ce = 1'b1; // always running
    logic rx_line; // serial line from the model
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic rx_irq;
    logic [31:0] rd; // last read word
    int n_fail = 0;
    int comparisons = 0;

    // clock, half period 2 ns
    always #2 clk = ~clk;

    asr_rx i_asr_rx (.clk(clk), .rstn(rstn), .ce(ce), .rx_pin(rx_line),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .rx_irq(rx_irq));
    // two clocks per tick, so a one-tick flip outlives the synchroniser filter
    asr_tx_model #(.DIV(2)) i_asr_tx_model (.clk(clk), .line(rx_line));

    // compare and count
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one avalon access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        // only the watchdog ends a wait that never completes
        do
        begin
            @(posedge clk);
        end
        while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask

    // expected status word
    function automatic logic [31:0] st(input logic f, input logic n, input logic e);
        return (32'(f) << asr_pkg::POS_FULL) | (32'(n) << asr_pkg::POS_NOISE)
            | (32'(e) << asr_pkg::POS_FERR);
    endfunction

    // send one frame and judge flags, interrupt and data
    task automatic frame(input logic [8:0] d, input int nb, input logic stop, input int flip,
        input logic n, input logic e, input logic ie);
        bus(1'b1, asr_pkg::OFF_LINE_CTRL_ONE, {31'h0, nb == 9});
        bus(1'b1, asr_pkg::OFF_LINE_CTRL_TWO, {31'h0, ie});
        i_asr_tx_model.send(d, nb, stop, flip);
        chk("irq", {31'h0, rx_irq}, {31'h0, ie});
        bus(1'b0, asr_pkg::OFF_STATUS_ONE, 32'h0);
        chk("status", rd, st(1'b1, n, e));
        bus(1'b0, asr_pkg::OFF_DATA_HIGH, 32'h0);
        chk("ninth", rd, 32'(d[8] && nb == 9) << asr_pkg::POS_NINTH);
        bus(1'b0, asr_pkg::OFF_DATA_LOW, 32'h0);
        chk("data", rd, {24'h0, d[7:0]});
        bus(1'b0, asr_pkg::OFF_STATUS_ONE, 32'h0);
        chk("cleared", rd, 32'h0);
    endtask

    // reset values, unmapped read included, then one tick per two clocks
    task automatic t_reset();
        for (int a = 0; a < 28; a += 4)
        begin
            bus(1'b0, 5'(a), 32'h0);
            chk("reset value", rd, (a == 20) ? {16'h0, asr_pkg::TICK_DIV_RST} : 32'h0);
        end
        chk("irq reset", {31'h0, rx_irq}, 32'h0);
        bus(1'b1, asr_pkg::OFF_TICK_DIV, 32'h00000002);
    endtask

    // clean, nine bit, framing error and break frames
    task automatic t_frames();
        frame(9'h0A5, 8, 1'b1, -1, 1'b0, 1'b0, 1'b1);
        frame(9'h1C3, 9, 1'b1, -1, 1'b0, 1'b0, 1'b0);
        frame(9'h055, 8, 1'b0, -1, 1'b0, 1'b1, 1'b1);
        frame(9'h000, 8, 1'b0, -1, 1'b0, 1'b1, 1'b1);
    endtask

    // software writes to data and status are ignored
    task automatic t_readonly();
        bus(1'b1, asr_pkg::OFF_DATA_LOW, 32'h000000FF);
        bus(1'b1, asr_pkg::OFF_STATUS_ONE, 32'h000000FF);
        // status first: a data read would clear the flags
        bus(1'b0, asr_pkg::OFF_STATUS_ONE, 32'h0);
        chk("status read only", rd, 32'h0);
        bus(1'b0, asr_pkg::OFF_DATA_LOW, 32'h0);
        chk("data read only", rd, 32'h0);
    endtask

    // rejected glitch leaves flags clear, next frame still found
    task automatic t_glitch();
        i_asr_tx_model.glitch(3);
        bus(1'b0, asr_pkg::OFF_STATUS_ONE, 32'h0);
        chk("glitch status", rd, 32'h0);
        frame(9'h03C, 8, 1'b1, -1, 1'b0, 1'b0, 1'b0);
    endtask

    // single noisy sample at start rt3, start rt8, data rt9 and stop rt9
    task automatic t_noise();
        int fl[4];
        fl = '{3, 8, 57, 153};
        foreach (fl[i])
            frame(9'h096, 8, 1'b1, fl[i], 1'b1, 1'b0, 1'b1);
    endtask

    // verdict, the single end of the run
    task automatic complete_run();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // main sequence
    initial
    begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_frames();
        t_readonly();
        t_glitch();
        t_noise();
        complete_run();
    end

    // watchdog against a hang
    initial
    begin
        #100000;
        n_fail++;
        complete_run();
    end
endmodule // tb_top
